// ===== hdl/ibc_master.sv
// two-wire bus master controller core, driven by commands from outside
`timescale 1ns/1ns
module ibc_master #(
  parameter int P_HALF_CYC = ibc_pkg::SCL_HALF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire ibc_pkg::ibc_cmd_t i_cmd,
  output logic o_ready,
  output ibc_pkg::ibc_rsp_t o_rsp,
  output logic o_bus_busy,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe
);
  localparam logic [ibc_pkg::CNT_W-1:0] HALF_END =
    ibc_pkg::CNT_W'(P_HALF_CYC - 1);
  localparam logic [ibc_pkg::CNT_W-1:0] CNT_ONE = 8'h01;

  generate
    if (P_HALF_CYC < 2 || P_HALF_CYC > 255) begin : g_bad_half
      $error("P_HALF_CYC out of range");
    end
  endgenerate

  ibc_pkg::ibc_regs_t s;
  ibc_pkg::ibc_regs_t n;
  logic bit_val;
  logic tx_bit;
  logic bit_end;

  always_comb begin
    n = s;
    n.scl_m = i_scl;
    n.scl_s = s.scl_m;
    n.sda_m = i_sda;
    n.sda_s = s.sda_m;
    n.sda_p = s.sda_s;
    n.rsp = '0;
    n.drv_lvl = 1'b0;
    bit_val = s.scl_s ? s.sda_s : s.smp;
    tx_bit = s.is_rd ? (s.bit_cnt == ibc_pkg::LAST_BIT) :
      (s.bit_cnt != ibc_pkg::LAST_BIT);
    bit_end = (s.seen_high && !s.scl_s) || (s.scl_s && s.cnt == HALF_END);
    // watch the wire, so other masters' frames also mark the bus busy
    if (s.scl_s && s.sda_p && !s.sda_s) begin
      n.busy = 1'b1;
    end
    if (s.scl_s && !s.sda_p && s.sda_s) begin
      n.busy = 1'b0;
    end
    case (s.state)
      ibc_pkg::ST_IDLE: begin
        if (i_cmd.valid && s.ready) begin
          n.ready = 1'b0;
          if (i_cmd.op == ibc_pkg::OP_START && !s.busy && s.scl_s &&
              s.sda_s) begin
            n.state = ibc_pkg::ST_START_A;
            n.sda_oe = 1'b1;
            n.cnt = '0;
            n.sh = {i_cmd.addr, i_cmd.rw, 1'b1};
            n.is_rd = 1'b0;
            n.nack = 1'b0;
          end else begin
            n.ready = 1'b1;
            n.rsp.done = 1'b1;
            n.rsp.refused = 1'b1;
          end
        end
      end
      ibc_pkg::ST_START_A: begin
        if (s.cnt == HALF_END) begin
          n.cnt = '0;
          n.scl_oe = 1'b1;
          n.bit_cnt = '0;
          n.state = ibc_pkg::ST_LOW;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end
      ibc_pkg::ST_LOW: begin
        n.sda_oe = ~s.sh[8];
        if (s.cnt == HALF_END) begin
          n.cnt = '0;
          n.scl_oe = 1'b0;
          n.seen_high = 1'b0;
          n.state = ibc_pkg::ST_HIGH;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end
      ibc_pkg::ST_HIGH: begin
        // high time counts only once the wire is really high
        if (s.scl_s) begin
          n.seen_high = 1'b1;
          n.smp = s.sda_s;
          n.cnt = s.cnt + CNT_ONE;
        end
        if (bit_end) begin
          n.cnt = '0;
          if (tx_bit && !s.sda_oe && !bit_val) begin
            // someone else drove low over our one: release both lines and report arb_lost
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.state = ibc_pkg::ST_IDLE;
            n.ready = 1'b1;
            n.rsp.done = 1'b1;
            n.rsp.arb_lost = 1'b1;
          end else begin
            n.scl_oe = 1'b1;
            n.sh = {s.sh[7:0], 1'b1};
            if (s.bit_cnt == ibc_pkg::LAST_BIT) begin
              n.state = ibc_pkg::ST_HOLD;
              n.ready = 1'b1;
              n.rsp.done = 1'b1;
              n.rsp.ack_seen = !bit_val;
              n.rsp.rdata = s.rx;
            end else begin
              n.rx = {s.rx[6:0], bit_val};
              n.bit_cnt = s.bit_cnt + 4'h1;
              n.state = ibc_pkg::ST_LOW;
            end
          end
        end
      end
      ibc_pkg::ST_HOLD: begin
        n.sda_oe = 1'b0;
        if (i_cmd.valid && s.ready) begin
          n.ready = 1'b0;
          n.cnt = '0;
          n.bit_cnt = '0;
          case (i_cmd.op)
            ibc_pkg::OP_START: begin
              n.sh = {i_cmd.addr, i_cmd.rw, 1'b1};
              n.is_rd = 1'b0;
              n.state = ibc_pkg::ST_RS_A;
            end
            ibc_pkg::OP_WRITE: begin
              n.sh = {i_cmd.wdata, 1'b1};
              n.is_rd = 1'b0;
              n.state = ibc_pkg::ST_LOW;
            end
            ibc_pkg::OP_READ: begin
              n.sh = {8'hff, i_cmd.nack};
              n.nack = i_cmd.nack;
              n.is_rd = 1'b1;
              n.state = ibc_pkg::ST_LOW;
            end
            default: begin
              n.sda_oe = 1'b1;
              n.state = ibc_pkg::ST_STOP_A;
            end
          endcase
        end
      end
      ibc_pkg::ST_RS_A: begin
        if (s.cnt == HALF_END) begin
          n.cnt = '0;
          n.scl_oe = 1'b0;
          n.state = ibc_pkg::ST_RS_B;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end
      ibc_pkg::ST_RS_B: begin
        if (s.scl_s) begin
          if (s.cnt == HALF_END) begin
            n.cnt = '0;
            n.sda_oe = 1'b1;
            n.state = ibc_pkg::ST_START_A;
          end else begin
            n.cnt = s.cnt + CNT_ONE;
          end
        end
      end
      ibc_pkg::ST_STOP_A: begin
        if (s.cnt == HALF_END) begin
          n.cnt = '0;
          n.scl_oe = 1'b0;
          n.state = ibc_pkg::ST_STOP_B;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end
      ibc_pkg::ST_STOP_B: begin
        if (s.scl_s) begin
          if (s.cnt == HALF_END) begin
            n.cnt = '0;
            n.sda_oe = 1'b0;
            n.state = ibc_pkg::ST_STOP_C;
          end else begin
            n.cnt = s.cnt + CNT_ONE;
          end
        end
      end
      ibc_pkg::ST_STOP_C: begin
        // bus free time before the next frame may start
        if (s.cnt == HALF_END) begin
          n.cnt = '0;
          n.state = ibc_pkg::ST_IDLE;
          n.ready = 1'b1;
          n.rsp.done = 1'b1;
        end else begin
          n.cnt = s.cnt + CNT_ONE;
        end
      end
      default: begin
        n = ibc_pkg::REGS_RST;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s <= ibc_pkg::REGS_RST;
    end else begin
      s <= n;
    end
  end

  assign o_ready = s.ready;
  assign o_rsp = s.rsp;
  assign o_bus_busy = s.busy;
  assign o_scl_o = s.drv_lvl;
  assign o_scl_oe = s.scl_oe;
  assign o_sda_o = s.drv_lvl;
  assign o_sda_oe = s.sda_oe;

  property p_low_only;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      !o_scl_o && !o_sda_o;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("pin driven to a high level");

  property p_start_shape;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(o_sda_oe) && !o_scl_oe |->
        s.state == ibc_pkg::ST_START_A && $past(s.sda_s) && $past(s.scl_s);
  endproperty
  a_start_shape: assert property (p_start_shape)
    else $error("sda fell with scl released outside a start");

  property p_ack_released;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_LOW && !s.is_rd &&
        s.bit_cnt == ibc_pkg::LAST_BIT && s.cnt != '0 |-> !o_sda_oe;
  endproperty
  a_ack_released: assert property (p_ack_released)
    else $error("master drove sda on the acknowledge clock of a write");

  property p_bit_range;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_HOLD && $past(s.state) == ibc_pkg::ST_HIGH
        |-> $past(s.bit_cnt) == ibc_pkg::LAST_BIT && s.bit_cnt <= 4'h8;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("byte ended before the ninth clock");

  property p_sda_while_low;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $changed(o_sda_oe) && s.state != ibc_pkg::ST_START_A &&
        s.state != ibc_pkg::ST_STOP_C && s.state != ibc_pkg::ST_IDLE
        |-> o_scl_oe && $past(o_scl_oe);
  endproperty
  a_sda_while_low: assert property (p_sda_while_low)
    else $error("sda changed while scl released");

  property p_read_ack;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_LOW && s.is_rd &&
        s.bit_cnt == ibc_pkg::LAST_BIT && s.cnt != '0 |-> o_sda_oe == !s.nack;
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("read acknowledge level does not match request");

  property p_stop_shape;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_STOP_B && n.state == ibc_pkg::ST_STOP_C
        |=> !o_sda_oe && !o_scl_oe && $past(o_sda_oe);
  endproperty
  a_stop_shape: assert property (p_stop_shape)
    else $error("stop did not raise sda with scl high");

  property p_restart;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_RS_B && s.scl_s && s.cnt == HALF_END
        |=> s.state == ibc_pkg::ST_START_A && o_sda_oe && !o_scl_oe;
  endproperty
  a_restart: assert property (p_restart)
    else $error("repeated start did not follow the released clock");

  property p_short_high;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_HIGH && s.seen_high && !s.scl_s
        |=> s.state != ibc_pkg::ST_HIGH;
  endproperty
  a_short_high: assert property (p_short_high)
    else $error("high phase kept after another master pulled scl low");

  property p_stretch;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      s.state == ibc_pkg::ST_HIGH && !s.scl_s && !s.seen_high
        |=> s.cnt == '0 && !o_scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("high count ran while scl was stretched low");
endmodule // ibc_master

// ===== hdl/ibc_pkg.sv
// constants and types for the two-wire bus master controller
// Operation
// - drive SDA and SCL only low or released, never high.
// - begin with SDA falling while SCL high, only when bus idle.
// - first byte after START is seven address bits plus direction bit.
// - only the addressed slave acknowledges, pulling SDA low on ninth clock.
// - bytes are eight bits, MSB first, ninth clock carries acknowledge.
// - transmitter changes SDA only while SCL low, stable while high.
// - slave not acknowledging leaves SDA high; master stops or restarts.
// - master receiver withholding acknowledge ends the slave's data.
// - STOP is SDA rising while SCL high, freeing the bus.
// - master may STOP after an acknowledge; slave then releases.
// - repeated START may follow without STOP, keeping the bus.
// - merged SCL has longest low and shortest high of masters.
// - slave may hold SCL low after nine bits; master waits.
// - slave may stretch any SCL low; master honours it.
package ibc_pkg;
  localparam int SYS_CLK_MHZ = 20;
  localparam int SCL_HALF_NS = 200;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} ibc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START_A, ST_LOW, ST_HIGH, ST_HOLD,
    ST_RS_A, ST_RS_B, ST_STOP_A, ST_STOP_B, ST_STOP_C
  } ibc_state_t;

  typedef struct packed {
    logic valid;
    ibc_op_t op;
    logic [6:0] addr;
    logic rw;
    logic [7:0] wdata;
    logic nack;
  } ibc_cmd_t;

  typedef struct packed {
    logic done;
    logic ack_seen;
    logic arb_lost;
    logic refused;
    logic [7:0] rdata;
  } ibc_rsp_t;

  typedef struct packed {
    ibc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bit_cnt;
    logic [8:0] sh;
    logic [7:0] rx;
    logic smp;
    logic seen_high;
    logic is_rd;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic drv_lvl;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic busy;
    logic ready;
    ibc_rsp_t rsp;
  } ibc_regs_t;

  localparam ibc_regs_t REGS_RST = '{
    state: ST_IDLE, ready: 1'b1, scl_m: 1'b1, scl_s: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0
  };
endpackage

// ===== testbench/ibc_slave_model.sv
// behavioural slave device with one data byte, for the master's far side
`timescale 1ns/1ns
module ibc_slave_model #(
  parameter logic [6:0] P_ADDR = 7'h2a
) (
  input wire logic i_sys_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_stretch,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  logic [7:0] sh = 8'h00;
  logic [7:0] mem = 8'h00;
  logic act = 1'b0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  initial begin
    o_scl_oe <= 1'b0;
    o_sda_oe = 1'b0;
  end
  // start and stop are the only sda moves while scl is high
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      n = 0;
      o_sda_oe = 1'b0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b0;
      o_sda_oe = 1'b0;
    end
  end
  always @(posedge i_scl) begin
    if (act) begin
      if (n < 8)
        sh = {sh[6:0], i_sda};
      else if (rd && !adr && i_sda)
        act = 1'b0;
      n = n + 1;
    end
  end
  // drive only after scl falls, so data is stable while scl is high
  always @(negedge i_scl) begin
    if (act && n == 8) begin
      if (adr) begin
        rd = sh[0];
        act = (sh[7:1] == P_ADDR);
      end else if (!rd)
        mem = sh;
      o_sda_oe = act && (adr || !rd);
    end else if (act && n == 9) begin
      n = 0;
      adr = 1'b0;
      o_sda_oe = rd && !mem[7];
      if (i_stretch != 8'h00) begin
        o_scl_oe <= 1'b1;
        repeat (i_stretch) @(posedge i_sys_clk);
        // release on the edge by nba so the master samples it race free
        o_scl_oe <= 1'b0;
      end
    end else if (act && n > 0)
      o_sda_oe = rd && !adr && !mem[7 - n];
  end
endmodule // ibc_slave_model

// ===== testbench/test_ibc_master.sv
// self-checking bench for the two-wire bus master
`timescale 1ns/1ns
module test_ibc_master;
  typedef struct packed {
    ibc_pkg::ibc_op_t op;
    logic [6:0] addr;
    logic rw;
    logic [7:0] wdata;
    logic nack;
    logic [3:0] exp;
  } ibc_row_t;
  localparam logic [6:0] ADDR = 7'h2a;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  ibc_pkg::ibc_cmd_t cmd = '0;
  ibc_pkg::ibc_rsp_t rsp, r;
  logic ready, busy, rb, scl_o, sda_o, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
  logic tb_sda_oe = 1'b0;
  logic tb_scl_oe = 1'b0;
  logic [7:0] stretch = 8'h00;
  int n_fail = 0;
  int checks = 0;
  int dur;
  ibc_row_t rows [9];
  wire scl_w = !(m_scl_oe | s_scl_oe | tb_scl_oe);
  wire sda_w = !(m_sda_oe | s_sda_oe | tb_sda_oe);
  ibc_master i_ibc_master (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_cmd(cmd), .o_ready(ready), .o_rsp(rsp), .o_bus_busy(busy),
    .i_scl(scl_w), .o_scl_o(scl_o), .o_scl_oe(m_scl_oe),
    .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(m_sda_oe));
  ibc_slave_model #(.P_ADDR(ADDR)) i_ibc_slave_model (.i_sys_clk(i_sys_clk),
    .i_scl(scl_w), .i_sda(sda_w), .i_stretch(stretch),
    .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe));
  initial forever #25 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hold the command until taken, then wait bounded for its answer
  task automatic run(input ibc_row_t w);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    cmd <= '{1'b1, w.op, w.addr, w.rw, w.wdata, w.nack};
    // ready is read settled, before the edge that takes the command
    #1;
    while (ready !== 1'b1 && k < 50) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    @(posedge i_sys_clk);
    cmd <= '0;
    dur = 0;
    #1;
    while (rsp.done !== 1'b1 && dur < 3000) begin
      @(posedge i_sys_clk);
      #1;
      dur++;
    end
    r = rsp;
    repeat (4) @(posedge i_sys_clk);
    #1;
    rb = busy;
  endtask

  initial begin
    #(30000 * 50);
    n_fail++;
    wrap_up;
  end

  initial begin
    rows = '{
      '{ibc_pkg::OP_WRITE, 7'h00, 1'b0, 8'h00, 1'b0, 4'h8},
      '{ibc_pkg::OP_START, ADDR, 1'b0, 8'h00, 1'b0, 4'h5},
      '{ibc_pkg::OP_WRITE, 7'h00, 1'b0, 8'ha5, 1'b0, 4'h5},
      '{ibc_pkg::OP_START, ADDR, 1'b1, 8'h00, 1'b0, 4'h5},
      '{ibc_pkg::OP_READ, 7'h00, 1'b0, 8'ha5, 1'b0, 4'h5},
      '{ibc_pkg::OP_READ, 7'h00, 1'b0, 8'ha5, 1'b1, 4'h1},
      '{ibc_pkg::OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0, 4'h0},
      '{ibc_pkg::OP_START, 7'h15, 1'b0, 8'h00, 1'b0, 4'h1},
      '{ibc_pkg::OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0, 4'h0}
    };
    repeat (19) @(posedge i_sys_clk);
    #1;
    chk({ready, m_scl_oe, m_sda_oe, busy, rsp.done, scl_o, sda_o},
      7'h40);
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    foreach (rows[i]) begin
      run(rows[i]);
      chk({r.done, r.refused, r.ack_seen & (rows[i].op != ibc_pkg::OP_STOP),
        r.arb_lost, rb}, {1'b1, rows[i].exp});
      if (rows[i].op == ibc_pkg::OP_READ)
        chk(r.rdata, rows[i].wdata);
    end
    // long stretch after each byte: the next byte must wait it out
    stretch <= 8'hc8;
    run(ibc_row_t'{ibc_pkg::OP_START, ADDR, 1'b0, 8'h00, 1'b0, 4'h0});
    run(ibc_row_t'{ibc_pkg::OP_WRITE, 7'h00, 1'b0, 8'h3c, 1'b0, 4'h0});
    chk({r.done, r.ack_seen, dur > 200}, 3'h7);
    stretch <= 8'h00;
    // a rival cuts our first high short: the bit must end early
    fork
      run(ibc_row_t'{ibc_pkg::OP_WRITE, 7'h00, 1'b0, 8'h5a, 1'b0, 4'h0});
      begin
        @(posedge scl_w);
        repeat (2) @(posedge i_sys_clk);
        tb_scl_oe <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        tb_scl_oe <= 1'b0;
      end
    join
    chk({r.done, r.ack_seen, r.arb_lost}, 3'h6);
    run(ibc_row_t'{ibc_pkg::OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0, 4'h0});
    chk({r.done, rb}, 2'h2);
    // a rival pulls sda low while we send a one in the address
    fork
      run(ibc_row_t'{ibc_pkg::OP_START, 7'h7f, 1'b0, 8'h00, 1'b0, 4'h0});
      begin
        @(posedge m_scl_oe);
        @(posedge i_sys_clk);
        tb_sda_oe <= 1'b1;
      end
    join
    chk({r.done, r.arb_lost, rb, m_scl_oe, m_sda_oe}, 5'h1c);
    run(ibc_row_t'{ibc_pkg::OP_START, ADDR, 1'b0, 8'h00, 1'b0, 4'h0});
    chk({r.done, r.refused}, 2'h3);
    @(posedge i_sys_clk);
    tb_sda_oe <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk(busy, 1'b0);
    // reset while we hold scl low after an address, then a fresh call
    run(ibc_row_t'{ibc_pkg::OP_START, ADDR, 1'b0, 8'h00, 1'b0, 4'h0});
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk({ready, m_scl_oe, m_sda_oe, busy, rsp.done, scl_o, sda_o},
      7'h40);
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    run(ibc_row_t'{ibc_pkg::OP_START, ADDR, 1'b0, 8'h00, 1'b0, 4'h0});
    chk({r.done, r.ack_seen, rb}, 3'h7);
    run(ibc_row_t'{ibc_pkg::OP_STOP, 7'h00, 1'b0, 8'h00, 1'b0, 4'h0});
    chk({r.done, rb}, 2'h2);
    wrap_up;
  end
endmodule // test_ibc_master
